// ==== core/dtp_host_port.sv ====
// Register port of the tone transceiver, reached over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module dtp_host_port
  import dtp_pkg::*;
#(
  parameter int unsigned BURST_CYCLES = DTP_BURST_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire dtp_rx_t rx_in,
  output dtp_tx_t tx_out,
  output logic irq,
  output logic interrupt_progress_output_n
);

  logic rst_meta_q;
  logic rst_n;
  dtp_ctrl_a_t cra_q;
  dtp_ctrl_b_t crb_q;
  logic steer_q;
  logic [3:0] mask_q;
  logic tx_empty_q;
  logic rx_full_q;
  logic [3:0] rx_data_q;
  logic [3:0] tx_code_q;
  logic start_q;
  logic burst_tone;
  logic burst_ready;
  logic req;
  logic take;
  logic wr_data;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_data;
  logic rd_status;
  dtp_status_t status;

  // Decode of an access to one word address, used for every register
  function automatic logic hit(input logic [1:0] addr, input logic [1:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // An access completes on the edge where waitrequest is seen low
  assign req = avs_read || avs_write;
  assign take = req && !avs_waitrequest;
  assign wr_data = take && avs_write && hit(avs_address, DTP_ADDR_DATA);
  assign wr_ctrl = take && avs_write && hit(avs_address, DTP_ADDR_CTRL);
  assign wr_mask = take && avs_write && hit(avs_address, DTP_ADDR_MASK);
  assign rd_data = take && avs_read && hit(avs_address, DTP_ADDR_DATA);
  assign rd_status = take && avs_read && hit(avs_address, DTP_ADDR_CTRL);

  // Live status; irq bit mirrors the two event flags
  always_comb
  begin
    status.steer_absent = !rx_in.tone_present;
    status.rx_full = rx_full_q;
    status.tx_empty = tx_empty_q;
    status.irq = tx_empty_q || rx_full_q;
  end

  // Bus handshake: one wait cycle, then one cycle with waitrequest low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else if (req && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      if (avs_read && hit(avs_address, DTP_ADDR_DATA))
      begin
        avs_readdata <= {{(DTP_DW-DTP_NIB){1'b0}}, rx_data_q};
      end
      else if (avs_read && hit(avs_address, DTP_ADDR_CTRL))
      begin
        avs_readdata <= {{(DTP_DW-DTP_NIB){1'b0}}, status};
      end
      else if (avs_read && hit(avs_address, DTP_ADDR_MASK))
      begin
        avs_readdata <= {{(DTP_DW-DTP_NIB){1'b0}}, mask_q};
      end
      else
      begin
        avs_readdata <= '0; // Unmapped reads answer zero
      end
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Control writes: bit 3 of A sends just the next write to B
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cra_q <= DTP_CRA_RST;
      crb_q <= DTP_CRB_RST;
      steer_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      if (steer_q)
      begin
        crb_q <= avs_writedata[DTP_NIB-1:0];
        steer_q <= 1'b0;
      end
      else
      begin
        cra_q <= avs_writedata[DTP_NIB-1:0];
        steer_q <= avs_writedata[DTP_NIB-1];
      end
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= DTP_MASK_RST;
    end
    else if (wr_mask)
    begin
      mask_q <= avs_writedata[DTP_NIB-1:0];
    end
  end

  // Transmit code load; a burst starts only in burst mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_code_q <= DTP_CODE_RST;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= wr_data && !crb_q.burst_off;
      if (wr_data)
      begin
        tx_code_q <= avs_writedata[DTP_NIB-1:0];
      end
    end
  end

  dtp_burst_timer #(
    .BURST_CYCLES(BURST_CYCLES)
  ) u_burst (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_q),
    .double(cra_q.cp_mode),
    .tone_on(burst_tone),
    .ready(burst_ready)
  );

  // Transmit-empty flag: set wins over a status-read clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_empty_q <= 1'b0;
    end
    else if (burst_ready && !crb_q.burst_off)
    begin
      tx_empty_q <= 1'b1;
    end
    else if (rd_status || crb_q.burst_off)
    begin
      tx_empty_q <= 1'b0;
    end
  end

  // Receive flag and latch; a tone in the read cycle is kept
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_full_q <= 1'b0;
      rx_data_q <= DTP_CODE_RST;
    end
    else if (rx_in.valid)
    begin
      rx_full_q <= 1'b1;
      rx_data_q <= rx_in.code;
    end
    else if (rd_status)
    begin
      rx_full_q <= 1'b0;
    end
  end

  // Tone outputs; outside burst mode the tone-out bit gates the tone
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_out <= '0;
    end
    else
    begin
      tx_out.enable <= crb_q.burst_off ? cra_q.tone_out : (burst_tone && cra_q.tone_out);
      tx_out.single <= crb_q.single;
      tx_out.column <= crb_q.column;
      tx_out.code <= tx_code_q;
    end
  end

  // Bus interrupt and the shared pin; the pin follows call progress or test first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      interrupt_progress_output_n <= 1'b1;
    end
    else
    begin
      irq <= |({1'b0, rx_full_q, tx_empty_q, 1'b0} & mask_q);
      if (cra_q.cp_mode)
      begin
        interrupt_progress_output_n <= rx_in.cp_detect;
      end
      else if (crb_q.test)
      begin
        interrupt_progress_output_n <= !rx_in.tone_present;
      end
      else
      begin
        interrupt_progress_output_n <= !(cra_q.irq_en && status.irq);
      end
    end
  end

  AST_TX_LOAD: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_data |=> tx_code_q == $past(avs_writedata[DTP_NIB-1:0]) ##1 tx_out.code == $past(tx_code_q))
    else $error("transmit code not loaded");

  AST_TX_READY: assert property (
    @(posedge clk) disable iff (!rst_n)
    burst_ready && !crb_q.burst_off |=> tx_empty_q ##1 (!interrupt_progress_output_n
      || !$past(cra_q.irq_en && !cra_q.cp_mode && !crb_q.test)))
    else $error("ready did not raise transmit empty");

  AST_RX_FULL: assert property (
    @(posedge clk) disable iff (!rst_n)
    rx_in.valid |=> rx_full_q && rx_data_q == $past(rx_in.code))
    else $error("received tone not flagged");

  AST_RX_READBACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avs_read && avs_waitrequest && hit(avs_address, DTP_ADDR_DATA))
      |=> avs_readdata[DTP_NIB-1:0] == $past(rx_data_q) && !avs_waitrequest)
    else $error("receive data read wrong");

  AST_STATUS_CLEAR: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_status && !rx_in.valid && !burst_ready |=> !rx_full_q && !tx_empty_q && !status.irq)
    else $error("status read did not clear flags");

  AST_STEER_ONCE: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_ctrl && steer_q |=> crb_q == $past(avs_writedata[DTP_NIB-1:0]) && !steer_q
      && cra_q == $past(cra_q))
    else $error("steered write went astray");

  AST_STEER_ARM: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_ctrl && !steer_q |=> steer_q == $past(avs_writedata[DTP_NIB-1]) && crb_q == $past(crb_q))
    else $error("control A write mishandled");

  AST_PIN_LOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    cra_q.irq_en && !cra_q.cp_mode && !crb_q.test && rx_full_q
      && $stable(cra_q) && $stable(crb_q) |=> !interrupt_progress_output_n)
    else $error("interrupt pin not pulled low");

endmodule : dtp_host_port
`default_nettype wire

// ==== core/dtp_pkg.sv ====
// Package with constants and types for the tone transceiver host port
// Operation
// - Burst mode emits each tone pair 50 ms (100 ms in call progress mode), then equal silence.
// - Data-address write loads a four-bit transmit digit code.
// - Status bit 1 sets in burst mode when the transmitter can take the next digit.
// - Status bit 2 sets on a received tone; host then reads receive data.
// - Status read clears the interrupt and receive-full flags.
// - Control A bit 3 steers only the next control write to control B.
// - Interrupts enabled in tone mode with test mode off pull the interrupt pin low on events.
package dtp_pkg;

  // Word addresses on the register bus (byte address is four times these)
  localparam logic [1:0] DTP_ADDR_DATA = 2'h0;
  localparam logic [1:0] DTP_ADDR_CTRL = 2'h1;
  localparam logic [1:0] DTP_ADDR_MASK = 2'h2;

  localparam int unsigned DTP_DW = 32;
  localparam int unsigned DTP_NIB = 4;

  // Timing of one burst and one pause
  localparam int unsigned DTP_BURST_MS = 50;
  localparam int unsigned DTP_CLK_KHZ = 50000;
  localparam int unsigned DTP_BURST_CYCLES = DTP_BURST_MS * DTP_CLK_KHZ;

  // Control register A fields
  typedef struct packed {
    logic sel_b;
    logic irq_en;
    logic cp_mode;
    logic tone_out;
  } dtp_ctrl_a_t;

  // Control register B fields
  typedef struct packed {
    logic column;
    logic single;
    logic test;
    logic burst_off;
  } dtp_ctrl_b_t;

  // Status register fields
  typedef struct packed {
    logic steer_absent;
    logic rx_full;
    logic tx_empty;
    logic irq;
  } dtp_status_t;

  // Receiver side inputs
  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic tone_present;
    logic cp_detect;
  } dtp_rx_t;

  // Transmitter side outputs
  typedef struct packed {
    logic enable;
    logic single;
    logic column;
    logic [3:0] code;
  } dtp_tx_t;

  localparam dtp_ctrl_a_t DTP_CRA_RST = 4'h0;
  localparam dtp_ctrl_b_t DTP_CRB_RST = 4'h0;
  localparam logic [3:0] DTP_MASK_RST = 4'h0;
  localparam logic [3:0] DTP_CODE_RST = 4'h0;

  // Burst timer states, Gray along idle, tone, pause
  typedef enum logic [1:0] {
    DTP_ST_IDLE = 2'b00,
    DTP_ST_TONE = 2'b01,
    DTP_ST_PAUSE = 2'b11
  } dtp_burst_st_t;

endpackage : dtp_pkg

// ==== core/dtp_burst_timer.sv ====
// Burst and pause sequencer for the transmitter
`timescale 1ns/1ps
`default_nettype none
module dtp_burst_timer
  import dtp_pkg::*;
#(
  parameter int unsigned BURST_CYCLES = DTP_BURST_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic double,
  output logic tone_on,
  output logic ready
);

  localparam int unsigned CW = $clog2(2 * BURST_CYCLES + 1);

  // Refuse lengths the counter cannot serve
  if (BURST_CYCLES < 2)
  begin : g_bad_len
    $error("dtp_burst_timer: BURST_CYCLES must be at least 2");
  end

  dtp_burst_st_t state_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] len;
  logic [CW-1:0] run_q;
  logic [CW-1:0] len_at_start_q;

  // Call progress mode doubles both burst and pause
  assign len = double ? CW'(2 * BURST_CYCLES) : CW'(BURST_CYCLES);

  // Sequence: tone for len, silence for len, then announce ready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= DTP_ST_IDLE;
      cnt_q <= '0;
      tone_on <= 1'b0;
      ready <= 1'b0;
    end
    else
    begin
      ready <= 1'b0;
      case (state_q)
        DTP_ST_IDLE:
        begin
          if (start)
          begin
            state_q <= DTP_ST_TONE;
            cnt_q <= len - CW'(1);
            tone_on <= 1'b1;
          end
        end
        DTP_ST_TONE:
        begin
          if (cnt_q == '0)
          begin
            state_q <= DTP_ST_PAUSE;
            cnt_q <= len - CW'(1);
            tone_on <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        DTP_ST_PAUSE:
        begin
          if (cnt_q == '0)
          begin
            state_q <= DTP_ST_IDLE;
            ready <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default:
        begin
          state_q <= DTP_ST_IDLE;
          tone_on <= 1'b0;
        end
      endcase
    end
  end

  // Helper: length of the current tone and the length chosen at its start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= '0;
      len_at_start_q <= '0;
    end
    else
    begin
      run_q <= tone_on ? run_q + CW'(1) : '0;
      if (state_q == DTP_ST_IDLE && start)
      begin
        len_at_start_q <= len;
      end
    end
  end

  AST_TONE_LENGTH: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(tone_on) |-> $past(run_q) + CW'(1) == len_at_start_q)
    else $error("tone burst length wrong");

  AST_PAUSE_THEN_READY: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(ready) |-> !tone_on && $past(state_q) == DTP_ST_PAUSE && $past(cnt_q) == '0)
    else $error("ready without a finished pause");

endmodule : dtp_burst_timer
`default_nettype wire

// ==== verification/dtp_host_model.sv ====
// Host bus master model for the tone transceiver register port
`timescale 1ns/1ps
`default_nettype none
module dtp_host_model
(
  input wire logic clk,
  output logic [1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic rd_vld,
  output logic [31:0] rd_q
);
  // Idle bus at time zero
  initial
  begin
    avs_address = 2'h3;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    rd_vld = 1'b0;
    rd_q = 32'h0;
  end

  // One access, held whole until waitrequest is seen low
  task automatic xfer(input logic w, input logic [1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    if (!w)
    begin
      rd_q <= avs_readdata;
      rd_vld <= 1'b1;
    end
    // Released address and data show the inverse, never a stale copy
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
    avs_address <= ~a;
    @(posedge clk);
    rd_vld <= 1'b0;
  endtask : xfer
endmodule : dtp_host_model
`default_nettype wire

// ==== verification/tb_dtmf_transceiver_host_port.sv ====
// Self-checking bench for the tone transceiver register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_dtmf_transceiver_host_port
  import dtp_pkg::*;
;
  localparam int BURST = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  dtp_rx_t rx = 7'h02;
  dtp_tx_t tx;
  logic irq;
  logic pin_n;
  logic rd_vld;
  logic [31:0] rd_q;
  logic [63:0] q[$];
  logic [63:0] ent;
  logic [3:0] c;
  int err_count = 0;
  int cmp_count = 0;
  int blen = BURST;

  // 50 MHz clock
  always #10 clk = ~clk;

  dtp_host_port #(.BURST_CYCLES(BURST)) dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_in(rx), .tx_out(tx), .irq(irq),
    .interrupt_progress_output_n(pin_n));

  dtp_host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rd_vld(rd_vld), .rd_q(rd_q));

  task automatic conclude();
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr

  // Note the expected word and care mask, then read
  task automatic rd(input logic [1:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e});
    host.xfer(1'b0, a, 32'h0);
  endtask : rd

  // Received digit strobe from the tone receiver
  task automatic rx_pulse(input logic [3:0] d);
    rx.code <= d;
    rx.valid <= 1'b1;
    @(posedge clk);
    rx.valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rx_pulse

  // Tone length exact, pause bounded by the flag lag
  task automatic burst_chk();
    int n;
    int g;
    g = 0;
    while (tx.enable !== 1'b1 && g < 50)
    begin
      @(posedge clk);
      g++;
    end
    n = 0;
    while (tx.enable === 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(n, blen)
    g = 0;
    while (irq !== 1'b1 && g < 200)
    begin
      @(posedge clk);
      g++;
    end
    `CHK(g >= blen && g <= blen + 3, 1'b1)
  endtask : burst_chk

  // Read results checked in arrival order
  always @(posedge clk)
  begin
    if (rd_vld === 1'b1)
    begin
      ent = q.pop_front();
      `CHK(rd_q & ent[63:32], ent[31:0])
    end
  end

  // Watchdog on a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'h6ac06416));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({irq, pin_n, tx}, 9'h080)
    // Power-up sequence; flags unknown before the first status read
    rd(DTP_ADDR_CTRL, 32'h0, ~32'h7);
    wr(DTP_ADDR_CTRL, 32'h0);
    wr(DTP_ADDR_CTRL, 32'h0);
    wr(DTP_ADDR_CTRL, 32'h8);
    wr(DTP_ADDR_CTRL, 32'h0);
    rd(DTP_ADDR_CTRL, 32'h0, ~32'h7);
    // Steering applies to one write only
    wr(DTP_ADDR_CTRL, 32'h8);
    wr(DTP_ADDR_CTRL, 32'h1);
    wr(DTP_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(tx.enable, 1'b1)
    wr(DTP_ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(tx.enable, 1'b0)
    wr(DTP_ADDR_MASK, 32'h6);
    rd(DTP_ADDR_MASK, 32'h6, '1);
    // Unmapped word: write dropped, read zero
    wr(2'h3, 32'hf);
    rd(2'h3, 32'h0, '1);
    // Burst transmit with interrupts
    wr(DTP_ADDR_CTRL, 32'hd);
    wr(DTP_ADDR_CTRL, 32'h0);
    c = 4'($urandom);
    wr(DTP_ADDR_DATA, {28'h0, c});
    burst_chk();
    `CHK(tx.code, c)
    `CHK(pin_n, 1'b0)
    rd(DTP_ADDR_CTRL, 32'h3, '1);
    rd(DTP_ADDR_CTRL, 32'h0, '1);
    repeat (2) @(posedge clk);
    `CHK({irq, pin_n}, 2'b01)
    // Received digit
    c = 4'($urandom);
    rx_pulse(c);
    `CHK({irq, pin_n}, 2'b10)
    rd(DTP_ADDR_CTRL, 32'h5, '1);
    rd(DTP_ADDR_DATA, {28'h0, c}, '1);
    // Both flags set: receive first, then next digit
    wr(DTP_ADDR_DATA, 32'h7);
    burst_chk();
    c = 4'($urandom);
    rx_pulse(c);
    rd(DTP_ADDR_CTRL, 32'h7, '1);
    rd(DTP_ADDR_DATA, {28'h0, c}, '1);
    wr(DTP_ADDR_DATA, 32'h5);
    burst_chk();
    `CHK(tx.code, 4'h5)
    rx.tone_present <= 1'b0;
    @(posedge clk);
    rd(DTP_ADDR_CTRL, 32'hb, '1);
    // Call progress mode: doubled burst and pause, pin shows the detector
    wr(DTP_ADDR_CTRL, 32'hb);
    wr(DTP_ADDR_CTRL, 32'hc);
    rx.cp_detect <= 1'b1;
    blen = 2 * BURST;
    wr(DTP_ADDR_DATA, 32'h3);
    burst_chk();
    `CHK({pin_n, tx.single, tx.column, tx.code}, 7'h73)
    rx.cp_detect <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(pin_n, 1'b0)
    rd(DTP_ADDR_CTRL, 32'hb, '1);
    // Test mode: pin shows inverted steering, not the interrupt
    wr(DTP_ADDR_CTRL, 32'h8);
    wr(DTP_ADDR_CTRL, 32'h2);
    rx.tone_present <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({pin_n, tx.single}, 2'b00)
    rx.tone_present <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(pin_n, 1'b1)
    repeat (4) @(posedge clk);
    `CHK(q.size(), 0)
    conclude();
  end
endmodule : tb_dtmf_transceiver_host_port
`default_nettype wire
